// *** logic/dadc_device.sv ***
// Converter end: control pins, trim sequencing, output demux and strobe.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dadc_defines.svh"

// Functional notes
// - trim wait pin picks short or long delay.
// - power-down at power-up stalls delay counter.
// - extended mode always uses short delay.
// - edge select picks strobe edge for data.
// - controller writes config only with DES off.
// - DES feeds one input to both converters.
// - floating trim pin enables I-input DES, short.
// - extended mode selects DES source pair.
// - controller clears auto phase before power-up.
// - trim pin driven low before floating.
// - controller clears auto phase on clock trouble.
// - controller leaves auto DES before calibration.
// - full power-down all, Q power-down Q only.
// - powered-down lanes tristate, flush after full power-down wake.
// - power-down waits for running calibration end.
// - calibration requests ignored while powered down.
// - odd and even words on separate buses.
// - one strobe; DDR strobe at quarter rate.
// - outputs offset binary coded.
// - trim active flag high, strobe idle, during calibration.
// - request needs low then high minimum counts.
module dadc_device
  import dadc_pkg::*;
(
  // Link to the controller.
  dadc_if.dev             lnk,
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Converter samples, two's complement.
  input  wire logic [7:0] i_in_i,
  input  wire logic [7:0] i_in_q,
  input  wire logic [7:0] i_in_mid,
  // Status.
  output logic            o_des_active,
  output logic            o_powered_down
);

  localparam logic [7:0] DLY_SHORT = 8'(`DADC_DLY_SHORT_CYC);
  localparam logic [7:0] DLY_LONG  = 8'(`DADC_DLY_LONG_CYC);
  localparam logic [7:0] CAL_RUN   = 8'(`DADC_CAL_RUN_CYC);
  localparam logic [7:0] CAL_L     = 8'(`DADC_CAL_L_CYC);
  localparam logic [7:0] CAL_H     = 8'(`DADC_CAL_H_CYC);
  localparam logic [1:0] FLUSH     = 2'(`DADC_FLUSH_WORDS);

  // ==========================================================================
  // Pin synchronisers.
  logic [28:0] pin_s1_q;
  logic [28:0] pin_s2_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_q <= 29'h0;
      pin_s2_q <= 29'h0;
    end else begin
      pin_s1_q <= {lnk.reg_wr, lnk.reg_addr, lnk.reg_wdata, lnk.cal_req,
                   lnk.full_power_down, lnk.q_channel_power_down,
                   lnk.output_edge_select, lnk.ddr_select, lnk.ext_mode,
                   lnk.trim_wait_select, lnk.trim_float};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic        s_wr;
  logic [3:0]  s_addr;
  logic [15:0] s_wdata;
  logic        s_cal;
  logic        s_pd;
  logic        s_pdq;
  logic        s_edge;
  logic        s_ddr;
  logic        s_ext;
  logic        s_trim;
  logic        s_float;
  assign {s_wr, s_addr, s_wdata, s_cal, s_pd, s_pdq, s_edge, s_ddr, s_ext,
          s_trim, s_float} = pin_s2_q;

  // ==========================================================================
  // Device registers.
  logic        wr_prev_q;
  logic [15:0] ilv_q;
  logic [15:0] cfg_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_prev_q <= 1'b0;
      ilv_q     <= `DADC_ILV_RESET;
      cfg_q     <= `DADC_CFG_RESET;
    end else begin
      wr_prev_q <= s_wr;
      if (s_wr && !wr_prev_q && s_addr == `DADC_REG_ILV) begin
        ilv_q <= s_wdata;
      end
      if (s_wr && !wr_prev_q && s_addr == `DADC_REG_CONFIG) begin
        cfg_q <= s_wdata;
      end
    end
  end

  // ==========================================================================
  // Mode decode.
  logic des_armed_q;
  logic des;
  logic src_q;
  logic ddr;
  logic long_dly;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      des_armed_q <= 1'b0;
    end else if (!s_float && !s_trim) begin
      des_armed_q <= 1'b1;
    end
  end
  assign des      = s_ext ? ilv_q[`DADC_ILV_DES_EN]
                          : (s_float && des_armed_q);
  assign src_q    = s_ext && ilv_q[`DADC_ILV_DES_SRC_Q];
  assign ddr      = s_ext ? cfg_q[`DADC_CFG_DDR] : s_ddr;
  assign long_dly = !s_ext && !s_float && s_trim;

  // ==========================================================================
  // Calibration request filter.
  logic [7:0] low_cnt_q;
  logic [7:0] high_cnt_q;
  logic       cal_fire;
  assign cal_fire = s_cal && low_cnt_q == CAL_L &&
                    high_cnt_q == CAL_H - 8'h01;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt_q  <= 8'h00;
      high_cnt_q <= 8'h00;
    end else if (!s_cal) begin
      high_cnt_q <= 8'h00;
      if (low_cnt_q != CAL_L) begin
        low_cnt_q <= low_cnt_q + 8'h01;
      end
    end else begin
      if (cal_fire) begin
        low_cnt_q <= 8'h00;
      end
      if (high_cnt_q != CAL_H) begin
        high_cnt_q <= high_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Sequencer.
  dadc_dev_state_type state_q;
  logic [7:0]         dly_cnt_q;
  logic [7:0]         cal_cnt_q;
  logic               dly_done;
  logic               wake_fail;
  assign dly_done  = dly_cnt_q >= (long_dly ? DLY_LONG : DLY_SHORT) - 8'h01;
  assign wake_fail = des && ilv_q[`DADC_ILV_AUTO_PHASE];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= DADC_S_WAIT;
    end else begin
      unique case (state_q)
        DADC_S_WAIT: begin
          if (!s_pd && dly_done) begin
            state_q <= s_cal ? DADC_S_RUN : DADC_S_CAL;
          end
        end
        DADC_S_CAL: begin
          if (cal_cnt_q == CAL_RUN - 8'h01) begin
            state_q <= s_pd ? DADC_S_PD : DADC_S_RUN;
          end
        end
        DADC_S_RUN: begin
          if (s_pd) begin
            state_q <= DADC_S_PD;
          end else if (cal_fire) begin
            state_q <= DADC_S_CAL;
          end
        end
        DADC_S_PD: begin
          if (!s_pd && !wake_fail) begin
            state_q <= DADC_S_RUN;
          end
        end
        default: state_q <= DADC_S_WAIT;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dly_cnt_q <= 8'h00;
    end else if (state_q == DADC_S_WAIT && !s_pd && !dly_done) begin
      dly_cnt_q <= dly_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_cnt_q <= 8'h00;
    end else if (state_q == DADC_S_CAL) begin
      cal_cnt_q <= cal_cnt_q + 8'h01;
    end else begin
      cal_cnt_q <= 8'h00;
    end
  end

  // ==========================================================================
  // Output demux, flush and strobe.
  logic       run;
  logic       ph_q;
  logic       upd;
  logic [1:0] flush_q;
  logic       strobe_q;
  logic       trim_q;
  logic [3:0] oe_q;
  logic [7:0] conv [2];
  logic [7:0] held_q [2];
  logic [7:0] lane_q [4];
  assign run = state_q == DADC_S_RUN;
  assign upd = run && ph_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_q    <= 1'b0;
      flush_q <= FLUSH;
    end else begin
      ph_q <= run ? !ph_q : 1'b0;
      if (state_q == DADC_S_PD) begin
        flush_q <= FLUSH;
      end else if (upd && flush_q != 2'h0) begin
        flush_q <= flush_q - 2'h1;
      end
    end
  end

  always_comb begin
    conv[0] = (des && src_q) ? i_in_q : i_in_i;
    conv[1] = des ? i_in_mid : (s_pdq ? 8'h00 : i_in_q);
  end

  for (genvar c = 0; c < 2; c++) begin : g_conv
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        held_q[c]     <= 8'h00;
        lane_q[2*c]   <= 8'h00;
        lane_q[2*c+1] <= 8'h00;
      end else if (run && !ph_q) begin
        held_q[c] <= {~conv[c][7], conv[c][6:0]};
      end else if (upd) begin
        lane_q[2*c]   <= (flush_q != 2'h0) ? 8'h00 : held_q[c];
        lane_q[2*c+1] <= (flush_q != 2'h0) ? 8'h00
                         : {~conv[c][7], conv[c][6:0]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_q <= 1'b0;
    end else if (!run) begin
      strobe_q <= 1'b0;
    end else if (ddr) begin
      strobe_q <= upd ? !strobe_q : strobe_q;
    end else begin
      strobe_q <= upd ? s_edge : !s_edge;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trim_q         <= 1'b0;
      oe_q           <= 4'h0;
      o_des_active   <= 1'b0;
      o_powered_down <= 1'b0;
    end else begin
      trim_q         <= state_q == DADC_S_CAL;
      oe_q[1:0]      <= {2{state_q != DADC_S_PD}};
      oe_q[3:2]      <= {2{state_q != DADC_S_PD && !s_pdq}};
      o_des_active   <= des;
      o_powered_down <= state_q == DADC_S_PD;
    end
  end

  assign lnk.output_strobe    = strobe_q;
  assign lnk.self_trim_active = trim_q;
  assign lnk.bus_oe           = oe_q;
  assign lnk.bus_data         = {lane_q[3], lane_q[2], lane_q[1], lane_q[0]};

endmodule

`default_nettype wire

// *** logic/dadc_defines.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef DADC_DEFINES_SVH
`define DADC_DEFINES_SVH

// ==========================================================================
// Device register map.
`define DADC_REG_CONFIG      4'h0
`define DADC_REG_ILV         4'hd
`define DADC_ILV_RESET       16'h0000
`define DADC_CFG_RESET       16'h0000
`define DADC_ILV_DES_SRC_Q   13
`define DADC_ILV_AUTO_PHASE  14
`define DADC_ILV_DES_EN      15
`define DADC_CFG_DDR         0

// ==========================================================================
// Timing.
`define DADC_CLK_MHZ         40
`define DADC_DLY_SHORT_NS    1000
`define DADC_DLY_LONG_NS     4000
`define DADC_CAL_RUN_NS      2000
`define DADC_DLY_SHORT_CYC   ((`DADC_DLY_SHORT_NS * `DADC_CLK_MHZ + 999) / 1000)
`define DADC_DLY_LONG_CYC    ((`DADC_DLY_LONG_NS * `DADC_CLK_MHZ + 999) / 1000)
`define DADC_CAL_RUN_CYC     ((`DADC_CAL_RUN_NS * `DADC_CLK_MHZ + 999) / 1000)
`define DADC_CAL_L_CYC       16
`define DADC_CAL_H_CYC       16
`define DADC_FLUSH_WORDS     2
`define DADC_WR_HOLD_CYC     4
`define DADC_SYNC_MARGIN     4
`define DADC_CAL_WAIT_CYC    255

// ==========================================================================
// Controller register map.
`define DADC_HR_CTRL         4'h0
`define DADC_HR_DEV_ADDR     4'h1
`define DADC_HR_DEV_DATA     4'h2
`define DADC_HR_STATUS       4'h3
`define DADC_HR_CAP_I        4'h4
`define DADC_HR_CAP_Q        4'h5
`define DADC_HR_SHADOW       4'h6
`define DADC_CTRL_RESET      8'h01
`define DADC_CTRL_CAL_GO     7

`endif

// *** logic/dadc_pkg.sv ***
// Types shared by both ends.
package dadc_pkg;

  // ========================================================================
  // Device sequencing states.
  typedef enum logic [3:0] {
    DADC_S_WAIT = 4'b0001,
    DADC_S_CAL  = 4'b0010,
    DADC_S_RUN  = 4'b0100,
    DADC_S_PD   = 4'b1000
  } dadc_dev_state_type;

  // ========================================================================
  // Controller calibration states.
  typedef enum logic [5:0] {
    DADC_H_IDLE    = 6'b000001,
    DADC_H_DESOFF  = 6'b000010,
    DADC_H_LOW     = 6'b000100,
    DADC_H_HIGH    = 6'b001000,
    DADC_H_WAIT    = 6'b010000,
    DADC_H_RESTORE = 6'b100000
  } dadc_host_state_type;

endpackage

// *** logic/dadc_if.sv ***
// Pin bundle between the converter and its receiving controller.
`timescale 1ns/10ps
`default_nettype none

interface dadc_if;
  // ========================================================================
  // Controller to device.
  logic        cal_req;
  logic        full_power_down;
  logic        q_channel_power_down;
  logic        output_edge_select;
  logic        ddr_select;
  logic        ext_mode;
  logic        trim_out;
  logic        trim_oe;
  logic        reg_wr;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  // Trim wait select pin as seen by the device.
  logic        trim_wait_select;
  logic        trim_float;
  // ========================================================================
  // Device to controller.
  logic        output_strobe;
  logic [31:0] bus_data;
  logic [3:0]  bus_oe;
  logic        self_trim_active;

  // Undriven pin reads low and is flagged as floating.
  assign trim_wait_select = trim_oe & trim_out;
  assign trim_float       = ~trim_oe;

  modport dev (
    input  cal_req, full_power_down, q_channel_power_down,
    input  output_edge_select, ddr_select, ext_mode,
    input  trim_wait_select, trim_float, reg_wr, reg_addr, reg_wdata,
    output output_strobe, bus_data, bus_oe, self_trim_active
  );

  modport host (
    output cal_req, full_power_down, q_channel_power_down,
    output output_edge_select, ddr_select, ext_mode,
    output trim_out, trim_oe, reg_wr, reg_addr, reg_wdata,
    input  output_strobe, bus_data, bus_oe, self_trim_active
  );
endinterface

`default_nettype wire

// *** logic/dadc_host.sv ***
// Controller end: pin drive, device register writes and word capture.
`timescale 1ns/10ps
`default_nettype none
`include "dadc_defines.svh"

module dadc_host
  import dadc_pkg::*;
(
  // Link to the device.
  dadc_if.host             lnk,
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Software port.
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // System.
  input  wire logic        i_clock_fault,
  output logic             o_word_valid
);

  localparam logic [3:0] HOLD   = 4'(`DADC_WR_HOLD_CYC);
  localparam logic [7:0] LOW_N  = 8'(`DADC_CAL_L_CYC + `DADC_SYNC_MARGIN);
  localparam logic [7:0] HIGH_N = 8'(`DADC_CAL_H_CYC + `DADC_SYNC_MARGIN);
  localparam logic [7:0] WAIT_N = 8'(`DADC_CAL_WAIT_CYC);

  // ==========================================================================
  // Control register and write engine.
  dadc_host_state_type st_q;
  logic [7:0]  ctrl_q;
  logic [3:0]  dev_addr_q;
  logic [15:0] shadow_q;
  logic [15:0] save_q;
  logic        busy_q;
  logic [3:0]  eng_cnt_q;
  logic [3:0]  w_addr_q;
  logic [15:0] w_data_q;
  logic        pd_q;
  logic        fault_prev_q;
  logic        need_clr_q;
  logic        refused_q;
  logic        go;
  logic        sw_dev;
  logic        bad_cfg;
  logic        s_guard;
  logic        s_cal;
  logic        s_sw;
  logic        start;
  logic [3:0]  st_addr;
  logic [15:0] st_data;
  logic        ilv_des;
  assign ilv_des = ctrl_q[4] && shadow_q[`DADC_ILV_DES_EN];
  assign go      = i_wr && i_addr == `DADC_HR_CTRL &&
                   i_wdata[`DADC_CTRL_CAL_GO] && st_q == DADC_H_IDLE;
  assign sw_dev  = i_wr && i_addr == `DADC_HR_DEV_DATA;
  assign bad_cfg = dev_addr_q == `DADC_REG_CONFIG && ilv_des;
  assign s_guard = need_clr_q ||
                   (!ctrl_q[0] && pd_q && shadow_q[`DADC_ILV_AUTO_PHASE]);
  assign s_cal   = st_q == DADC_H_DESOFF || st_q == DADC_H_RESTORE;
  assign s_sw    = sw_dev && !bad_cfg;
  assign start   = !busy_q && (s_guard || s_cal || s_sw);

  always_comb begin
    st_addr = `DADC_REG_ILV;
    st_data = shadow_q & ~(16'h1 << `DADC_ILV_AUTO_PHASE);
    if (!s_guard && st_q == DADC_H_DESOFF) begin
      st_data = shadow_q & ~(16'h1 << `DADC_ILV_DES_EN);
    end else if (!s_guard && st_q == DADC_H_RESTORE) begin
      st_data = save_q;
    end else if (!s_guard && !s_cal) begin
      st_addr = dev_addr_q;
      st_data = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q    <= 1'b0;
      eng_cnt_q <= 4'h0;
      w_addr_q  <= 4'h0;
      w_data_q  <= 16'h0;
      shadow_q  <= `DADC_ILV_RESET;
    end else if (start) begin
      busy_q    <= 1'b1;
      eng_cnt_q <= 4'h0;
      w_addr_q  <= st_addr;
      w_data_q  <= st_data;
      if (st_addr == `DADC_REG_ILV) begin
        shadow_q <= st_data;
      end
    end else if (busy_q) begin
      eng_cnt_q <= eng_cnt_q + 4'h1;
      busy_q    <= eng_cnt_q != HOLD + HOLD - 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q       <= `DADC_CTRL_RESET;
      dev_addr_q   <= 4'h0;
      pd_q         <= 1'b1;
      fault_prev_q <= 1'b0;
      need_clr_q   <= 1'b0;
      refused_q    <= 1'b0;
    end else begin
      if (i_wr && i_addr == `DADC_HR_CTRL) begin
        ctrl_q <= {1'b0, i_wdata[6:0]};
      end
      if (i_wr && i_addr == `DADC_HR_DEV_ADDR) begin
        dev_addr_q <= i_wdata[3:0];
      end
      pd_q         <= ctrl_q[0] || (pd_q && (s_guard || busy_q));
      fault_prev_q <= i_clock_fault;
      need_clr_q   <= (i_clock_fault && !fault_prev_q) ||
                      (need_clr_q && !(start && s_guard));
      refused_q    <= (sw_dev && (busy_q || bad_cfg || s_guard || s_cal)) ||
                      (refused_q && !(i_rd && i_addr == `DADC_HR_STATUS));
    end
  end

  // ==========================================================================
  // Calibration request sequence.
  logic [7:0] cal_cnt_q;
  logic       had_des_q;
  logic       cal_pin_q;
  logic       seen_trim_q;
  logic [2:0] trim_s_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q        <= DADC_H_IDLE;
      cal_cnt_q   <= 8'h00;
      had_des_q   <= 1'b0;
      save_q      <= `DADC_ILV_RESET;
      cal_pin_q   <= 1'b0;
      seen_trim_q <= 1'b0;
    end else begin
      unique case (st_q)
        DADC_H_IDLE: begin
          if (go) begin
            had_des_q <= ilv_des;
            save_q    <= shadow_q;
            st_q      <= ilv_des ? DADC_H_DESOFF : DADC_H_LOW;
          end
        end
        DADC_H_DESOFF: begin
          if (start && !s_guard) begin
            st_q <= DADC_H_LOW;
          end
        end
        DADC_H_LOW: begin
          cal_cnt_q <= busy_q ? 8'h00 : cal_cnt_q + 8'h01;
          if (cal_cnt_q == LOW_N) begin
            cal_cnt_q <= 8'h00;
            cal_pin_q <= 1'b1;
            st_q      <= DADC_H_HIGH;
          end
        end
        DADC_H_HIGH: begin
          cal_cnt_q <= cal_cnt_q + 8'h01;
          if (cal_cnt_q == HIGH_N) begin
            cal_cnt_q   <= 8'h00;
            cal_pin_q   <= 1'b0;
            seen_trim_q <= 1'b0;
            st_q        <= DADC_H_WAIT;
          end
        end
        DADC_H_WAIT: begin
          cal_cnt_q   <= seen_trim_q ? cal_cnt_q : cal_cnt_q + 8'h01;
          seen_trim_q <= seen_trim_q || trim_s_q[1];
          if ((seen_trim_q && !trim_s_q[1]) || cal_cnt_q == WAIT_N) begin
            cal_cnt_q <= 8'h00;
            st_q      <= had_des_q ? DADC_H_RESTORE : DADC_H_IDLE;
          end
        end
        DADC_H_RESTORE: begin
          if (start && !s_guard) begin
            st_q <= DADC_H_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Trim pin drive and word capture.
  logic        seen_low_q;
  logic [2:0]  stb_s_q;
  logic [31:0] dat_s1_q;
  logic [31:0] dat_s2_q;
  logic [31:0] cap_q;
  logic        cap;
  assign cap = ctrl_q[3] ? (stb_s_q[1] != stb_s_q[2])
             : ctrl_q[2] ? (!stb_s_q[1] && stb_s_q[2])
             : (stb_s_q[1] && !stb_s_q[2]);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_low_q   <= 1'b0;
      trim_s_q     <= 3'h0;
      stb_s_q      <= 3'h0;
      dat_s1_q     <= 32'h0;
      dat_s2_q     <= 32'h0;
      cap_q        <= 32'h0;
      o_word_valid <= 1'b0;
      o_rdata      <= 16'h0;
    end else begin
      seen_low_q   <= 1'b1;
      trim_s_q     <= {trim_s_q[1:0], lnk.self_trim_active};
      stb_s_q      <= {stb_s_q[1:0], lnk.output_strobe};
      dat_s1_q     <= lnk.bus_data;
      dat_s2_q     <= dat_s1_q;
      o_word_valid <= cap;
      if (cap) begin
        cap_q <= dat_s2_q;
      end
      unique case (i_addr)
        `DADC_HR_CTRL:     o_rdata <= {8'h00, ctrl_q};
        `DADC_HR_DEV_ADDR: o_rdata <= {12'h000, dev_addr_q};
        `DADC_HR_STATUS:   o_rdata <= {12'h000, refused_q, pd_q,
                                       trim_s_q[1], busy_q || !st_q[0]};
        `DADC_HR_CAP_I:    o_rdata <= cap_q[15:0];
        `DADC_HR_CAP_Q:    o_rdata <= cap_q[31:16];
        `DADC_HR_SHADOW:   o_rdata <= shadow_q;
        default:           o_rdata <= 16'h0;
      endcase
    end
  end

  assign lnk.cal_req              = cal_pin_q;
  assign lnk.full_power_down      = pd_q;
  assign lnk.q_channel_power_down = ctrl_q[1];
  assign lnk.output_edge_select   = ctrl_q[2];
  assign lnk.ddr_select           = ctrl_q[3];
  assign lnk.ext_mode             = ctrl_q[4];
  assign lnk.trim_out             = ctrl_q[6];
  assign lnk.trim_oe              = !(ctrl_q[5] && seen_low_q && !ctrl_q[4]);
  assign lnk.reg_wr               = busy_q && eng_cnt_q < HOLD;
  assign lnk.reg_addr             = w_addr_q;
  assign lnk.reg_wdata            = w_data_q;

endmodule

`default_nettype wire

// *** sim/dadc_asserts.sv ***
// Link checks between the converter and its controller.
`timescale 1ns/10ps
`default_nettype none
module dadc_asserts (
  // Clock, reset and link signals.
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        full_power_down,
  input wire logic        q_channel_power_down,
  input wire logic        output_edge_select,
  input wire logic        ddr_select,
  input wire logic        ext_mode,
  input wire logic        output_strobe,
  input wire logic [31:0] bus_data,
  input wire logic [3:0]  bus_oe,
  input wire logic        self_trim_active
);
  logic [7:0] trim_q;
  logic [7:0] pd_q;
  logic       sdr;
  assign sdr = !ddr_select && !ext_mode;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trim_q <= 8'h00;
    end else begin
      trim_q <= self_trim_active ? trim_q + 8'h01 : 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_q <= 8'h00;
    end else begin
      pd_q <= !full_power_down ? 8'h00 : pd_q + {7'h00, pd_q != 8'hff};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================
  // Checks.
  cal_idle_a:
    assert property (self_trim_active |-> !output_strobe) else $error("st");
  cal_length_a:
    assert property ($fell(self_trim_active) |-> trim_q == 8'h50)
    else $error("cal length");
  cal_finish_a:
    assert property (self_trim_active && full_power_down && trim_q < 8'h4f
      |=> self_trim_active) else $error("cal cut");
  pd_quiet_a:
    assert property (pd_q == 8'hff |-> bus_oe == 4'h0 && !self_trim_active)
    else $error("pd");
  q_down_a:
    assert property (q_channel_power_down [*8] |-> bus_oe[3:2] == 2'b00)
    else $error("q lanes");
  edge_sel_a:
    assert property (sdr && $changed(bus_data) && $changed(output_strobe)
      |-> output_strobe == output_edge_select) else $error("edge");
  sdr_rate_a:
    assert property (sdr && $rose(output_strobe) |=> !output_strobe)
    else $error("sdr rate");
  ddr_rate_a:
    assert property (ddr_select && !ext_mode && $rose(output_strobe)
      |-> output_strobe [*2] ##1 !output_strobe) else $error("ddr rate");
  cover property ($fell(self_trim_active));
  cover property (ddr_select && $rose(output_strobe));
  cover property (pd_q == 8'hff);
endmodule
`default_nettype wire

// *** sim/dadc_tb_top.sv ***
// Bench joining both link ends.
`timescale 1ns/10ps
`default_nettype none
module dadc_tb_top;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  in_i = 8'h00, in_q = 8'h00, in_mid = 8'h00;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, got;
  logic        wr = 1'b0, rd = 1'b0, des_v, pd_v;
  logic        fault = 1'b0, wv;
  int          wv_n = 0;
  logic [7:0]  cfg [4] = '{8'h44, 8'h0c, 8'h54, 8'h60};
  int          errors = 0, cmp_count = 0, cyc = 0, n, d;
  dadc_if lnk ();
  always #12.5 i_clk = ~i_clk;
  dadc_device dadc_device_i (.lnk(lnk), .i_clk(i_clk), .i_resetn(i_resetn),
    .i_in_i(in_i), .i_in_q(in_q), .i_in_mid(in_mid),
    .o_des_active(des_v), .o_powered_down(pd_v));
  dadc_host dadc_host_i (.lnk(lnk), .i_clk(i_clk), .i_resetn(i_resetn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_clock_fault(fault), .o_word_valid(wv));
  dadc_asserts dadc_asserts_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .full_power_down(lnk.full_power_down),
    .q_channel_power_down(lnk.q_channel_power_down),
    .output_edge_select(lnk.output_edge_select),
    .ddr_select(lnk.ddr_select), .ext_mode(lnk.ext_mode),
    .output_strobe(lnk.output_strobe), .bus_data(lnk.bus_data),
    .bus_oe(lnk.bus_oe), .self_trim_active(lnk.self_trim_active));
  // ==========================================================
  // Tasks.
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_trim();
    for (n = 0; n < 400 && lnk.self_trim_active !== 1'b1; n++) begin
      @(posedge i_clk);
    end
  endtask
  always @(posedge i_clk) begin
    if (wv === 1'b1) begin
      wv_n <= wv_n + 1;
    end
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    n = $urandom(32'h4a508110);
    foreach (cfg[k]) begin
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (60) @(posedge i_clk);
      chk(16'h0, {15'h0, lnk.self_trim_active});
      wreg(4'h0, {8'h00, cfg[k]});
      wait_trim();
      d = (cfg[k] == 8'h44) ? 160 : 40;
      chk(16'h1, {15'h0, n >= d && n <= d + 24});
      in_i <= 8'($urandom);
      in_q <= 8'($urandom);
      in_mid <= 8'($urandom);
      repeat (150) @(posedge i_clk);
      rreg(4'h4);
      chk({2{in_i ^ 8'h80}}, got);
      rreg(4'h5);
      chk({2{(k == 3 ? in_mid : in_q) ^ 8'h80}}, got);
      chk({15'h0, k == 3}, {15'h0, des_v});
    end
    wreg(4'h0, 16'h00e0);
    wait_trim();
    chk(16'h1, {15'h0, lnk.self_trim_active});
    wreg(4'h0, 16'h0061);
    repeat (300) @(posedge i_clk);
    wreg(4'h0, 16'h00e1);
    repeat (300) @(posedge i_clk);
    chk(16'h0, {15'h0, lnk.self_trim_active});
    chk(16'h1, {15'h0, pd_v});
    chk(16'h0, {12'h0, lnk.bus_oe});
    rreg(4'h3);
    chk(16'h4, got & 16'h0004);
    wreg(4'h0, 16'h0062);
    repeat (100) @(posedge i_clk);
    chk(16'h3, {12'h0, lnk.bus_oe});
    chk(16'h1, {15'h0, wv_n > 0});
    wreg(4'h1, 16'h000d);
    wreg(4'h2, 16'h4000);
    repeat (20) @(posedge i_clk);
    rreg(4'h6);
    chk(16'h4000, got);
    fault <= 1'b1;
    @(posedge i_clk);
    fault <= 1'b0;
    repeat (20) @(posedge i_clk);
    rreg(4'h6);
    chk(16'h0000, got);
    rreg(4'hf);
    give_verdict();
  end
endmodule
`default_nettype wire
